// ===== design/sec_spi_eeprom.sv
// SPI EEPROM command slave: pin front end, command decoder, page buffer,
// array and self-timed programming. Pins are asynchronous to clk_i.
`timescale 1ns/100ps
`include "sec_defines.svh"
module sec_spi_eeprom
	import sec_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = `SEC_PROG_CYCLES // Programming length
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic cs_n_i,
	input  wire logic sck_i,
	input  wire logic si_i,
	input  wire logic wp_n_i,
	input  wire logic hold_n_i,
	output logic      so_o,
	output logic      so_oe_n_o
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [4:0] pin_raw; // Hold, protect, data, clock, select
	logic [4:0] s1;      // First stage, read by s2 only
	logic [4:0] s2;      // Second stage
	logic [4:0] s3;      // Third stage
	logic [4:0] filt;    // Accepted level
	logic [4:0] filt_d;  // Previous accepted level

	assign pin_raw = {hold_n_i, wp_n_i, si_i, sck_i, cs_n_i};

	// Idle pin levels, so reset leaves no false edge behind
	localparam logic [4:0] PIN_IDLE = `SEC_PIN_IDLE;

	// Change accepted once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (!rstn_i) begin
					s1[gi]     <= PIN_IDLE[gi];
					s2[gi]     <= PIN_IDLE[gi];
					s3[gi]     <= PIN_IDLE[gi];
					filt[gi]   <= PIN_IDLE[gi];
					filt_d[gi] <= PIN_IDLE[gi];
				end else begin
					s1[gi]     <= pin_raw[gi];
					s2[gi]     <= s1[gi];
					s3[gi]     <= s2[gi];
					filt[gi]   <= (s2[gi] == s3[gi]) ? s3[gi] : filt[gi];
					filt_d[gi] <= filt[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Edge detection
	logic cs_hi;     // Deselected
	logic cs_rise;   // Deselect edge
	logic cs_fall;   // Select edge
	logic sck_rise;  // Serial clock rising
	logic sck_fall;  // Serial clock falling
	logic si_b;      // Serial input level
	logic wp_lo;     // Protect pin asserted
	logic hold_fall; // Pause request
	logic hold_rise; // Resume request
	logic rise_ok;   // Rising edge that counts
	logic fall_ok;   // Falling edge that counts

	assign cs_hi     = filt[0];
	assign cs_rise   = filt[0] & ~filt_d[0];
	assign cs_fall   = ~filt[0] & filt_d[0];
	assign sck_rise  = filt[1] & ~filt_d[1];
	assign sck_fall  = ~filt[1] & filt_d[1];
	assign si_b      = filt[2];
	assign wp_lo     = ~filt[3];
	assign hold_fall = ~filt[4] & filt_d[4] & ~filt[1];
	assign hold_rise = filt[4] & ~filt_d[4] & ~filt[1];

	////////////////////////////////////////////////////////////////////////////
	// Serial command state
	sec_state_t  state, next_state;
	logic [3:0]  bcnt, next_bcnt;       // Bit count within field
	logic [15:0] sr, next_sr;           // Input shifter
	logic        is_rd, next_is_rd;     // Address belongs to a read
	logic [13:0] addr, next_addr;       // Byte address
	logic [7:0]  osr, next_osr;         // Output shifter
	logic        so_q, next_so;         // Output bit
	logic        oe_n, next_oe_n;       // Output enable, low drives
	logic        paused, next_paused;   // Transfer on hold
	logic        wdone, next_wdone;     // Last data byte complete
	logic        wen, next_wen;         // Write latch
	logic [7:0]  pg_base, next_pg_base; // Page of the write
	logic [63:0] pg_vld, next_pg_vld;   // Bytes loaded into buffer
	logic [7:0]  stat_new, next_stat;   // Pending status value
	logic [15:0] sh;                    // Shifter with new bit
	logic [7:0]  op;                    // Opcode, bit 3 masked
	logic [13:0] addr_inc;              // Streaming increment
	logic [7:0]  rd_byte;               // Status as seen by master
	logic        start_arr;             // Launch array programming
	logic        start_st;              // Launch status programming
	logic        pg_we;                 // Buffer byte strobe
	logic [7:0]  pg_data [0:63];        // Page buffer
	logic [7:0]  mem [0:16383];         // Array

	// Programming state, declared here for the decoder
	logic        busy, next_busy;       // Programming running
	logic [31:0] pcnt, next_pcnt;       // Cycle count
	logic        prog_st, next_prog_st; // Status rather than array
	logic        pin_en, next_pin_en;   // Protect pin enable
	logic [1:0]  bp, next_bp;           // Block protect field
	logic [13:0] prog_addr;             // Array byte being programmed
	logic        prot;                  // That byte is protected
	logic        mem_we;                // Array write strobe

	assign rise_ok  = sck_rise & ~paused & ~cs_hi & ~cs_fall;
	assign fall_ok  = sck_fall & ~paused & ~cs_hi & ~cs_fall & ~hold_fall & ~hold_rise;
	assign sh       = {sr[14:0], si_b};
	assign op       = sh[7:0] & `SEC_OP_MASK;
	assign addr_inc = addr + 14'h1;
	// Busy reads as all ones on the wire
	assign rd_byte  = busy ? `SEC_BUSY_BYTE : {pin_en, 3'h0, bp, wen, busy};

	// Decoder next values
	always_comb begin
		next_state   = state;
		next_bcnt    = bcnt;
		next_sr      = sr;
		next_is_rd   = is_rd;
		next_addr    = addr;
		next_osr     = osr;
		next_so      = so_q;
		next_oe_n    = oe_n;
		next_paused  = paused;
		next_wdone   = wdone;
		next_wen     = wen;
		next_pg_base = pg_base;
		next_pg_vld  = pg_vld;
		next_stat    = stat_new;
		start_arr    = 1'b0;
		start_st     = 1'b0;
		pg_we        = 1'b0;
		if (cs_hi) begin
			// Deselected: float output, drop pause
			next_state  = ST_IDLE;
			next_oe_n   = 1'b1;
			next_paused = 1'b0;
			next_wdone  = 1'b0;
			// Only an edge right after a whole byte launches programming
			if (cs_rise && wdone && wen) begin
				start_arr = (state == ST_WDAT);
				start_st  = (state == ST_SWR) && !(pin_en && wp_lo);
			end
			if (start_arr || start_st) begin
				next_wen = 1'b0;
			end
		end else if (cs_fall) begin
			next_state = ST_OPC;
			next_bcnt  = 4'h0;
		end else if (hold_fall) begin
			next_paused = 1'b1;
		end else if (hold_rise) begin
			next_paused = 1'b0;
		end else if (rise_ok) begin
			next_sr   = sh;
			next_bcnt = bcnt + 4'h1;
			unique case (state)
				ST_OPC: begin
					if (bcnt == 4'h7) begin
						next_bcnt  = 4'h0;
						next_state = ST_IGN;
						// While busy only the status read gets through
						if (!busy || op == `SEC_OP_SRD) begin
							case (op)
								`SEC_OP_READ: begin
									next_state = ST_ADDR;
									next_is_rd = 1'b1;
								end
								`SEC_OP_WRITE: begin
									if (wen) begin
										next_state = ST_ADDR;
										next_is_rd = 1'b0;
									end
								end
								`SEC_OP_LSET: next_wen = 1'b1;
								`SEC_OP_LCLR: next_wen = 1'b0;
								`SEC_OP_SRD: begin
									next_state = ST_SRD;
									next_osr   = rd_byte;
									next_oe_n  = 1'b0;
								end
								`SEC_OP_SWR: begin
									if (wen) begin
										next_state = ST_SWR;
									end
								end
								default: ;
							endcase
						end
					end
				end
				ST_ADDR: begin
					if (bcnt == 4'hf) begin
						next_bcnt = 4'h0;
						next_addr = sh[13:0];
						if (is_rd) begin
							next_state = ST_RDAT;
							next_osr   = mem[sh[13:0]];
							next_oe_n  = 1'b0;
						end else begin
							next_state   = ST_WDAT;
							next_pg_base = sh[13:6];
							next_pg_vld  = 64'h0;
						end
					end
				end
				ST_WDAT: begin
					next_wdone = 1'b0;
					if (bcnt == 4'h7) begin
						next_bcnt            = 4'h0;
						pg_we                = 1'b1;
						next_pg_vld[addr[5:0]] = 1'b1;
						// Low bits wrap inside the page
						next_addr  = {addr[13:6], addr_inc[5:0]};
						next_wdone = 1'b1;
					end
				end
				ST_SWR: begin
					if (wdone) begin
						// Extra bit after the byte spoils the write
						next_state = ST_IGN;
						next_wdone = 1'b0;
					end else if (bcnt == 4'h7) begin
						next_bcnt  = 4'h0;
						next_stat  = sh[7:0];
						next_wdone = 1'b1;
					end
				end
				// Data input is of no interest here
				ST_IDLE, ST_RDAT, ST_SRD, ST_IGN: begin
					next_sr   = sr;
					next_bcnt = bcnt; // Output states count falling edges only
				end
			endcase
		end else if (fall_ok && !oe_n) begin
			// Present next bit for the master's next rising edge
			next_so   = osr[7];
			next_osr  = {osr[6:0], 1'b0};
			next_bcnt = bcnt + 4'h1;
			if (bcnt == 4'h7) begin
				next_bcnt = 4'h0;
				if (state == ST_RDAT) begin
					next_addr = addr_inc;
					next_osr  = mem[addr_inc];
				end else begin
					next_osr = rd_byte;
				end
			end
		end
	end

	// Decoder registers; latch starts cleared
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state    <= ST_IDLE;
			bcnt     <= 4'h0;
			sr       <= 16'h0;
			is_rd    <= 1'b0;
			addr     <= 14'h0;
			osr      <= 8'h0;
			so_q     <= 1'b0;
			oe_n     <= 1'b1;
			paused   <= 1'b0;
			wdone    <= 1'b0;
			wen      <= 1'b0;
			pg_base  <= 8'h0;
			pg_vld   <= 64'h0;
			stat_new <= 8'h0;
		end else begin
			state    <= next_state;
			bcnt     <= next_bcnt;
			sr       <= next_sr;
			is_rd    <= next_is_rd;
			addr     <= next_addr;
			osr      <= next_osr;
			so_q     <= next_so;
			oe_n     <= next_oe_n;
			paused   <= next_paused;
			wdone    <= next_wdone;
			wen      <= next_wen;
			pg_base  <= next_pg_base;
			pg_vld   <= next_pg_vld;
			stat_new <= next_stat;
		end
	end

	// Page buffer fill, no reset needed for data
	always_ff @(posedge clk_i) begin
		if (pg_we) begin
			pg_data[addr[5:0]] <= sh[7:0];
		end
	end

	assign so_o      = so_q;
	assign so_oe_n_o = oe_n;

	////////////////////////////////////////////////////////////////////////////
	// Self-timed programming
	assign prog_addr = {pg_base, pcnt[5:0]};

	// Upper quarter, upper half or whole array
	always_comb begin
		unique case (bp)
			2'h0: prot = 1'b0;
			2'h1: prot = (prog_addr >= `SEC_BP01_BASE);
			2'h2: prot = (prog_addr >= `SEC_BP10_BASE);
			2'h3: prot = 1'b1;
		endcase
	end

	// One buffered byte per cycle, then wait out the cycle
	always_comb begin
		next_busy    = busy;
		next_pcnt    = pcnt;
		next_prog_st = prog_st;
		next_pin_en  = pin_en;
		next_bp      = bp;
		mem_we       = 1'b0;
		if (start_arr || start_st) begin
			next_busy    = 1'b1;
			next_pcnt    = 32'h0;
			next_prog_st = start_st;
		end else if (busy) begin
			next_pcnt = pcnt + 32'h1;
			if (prog_st) begin
				if (pcnt == 32'h0) begin
					next_pin_en = stat_new[`SEC_ST_PINEN];
					next_bp   = stat_new[`SEC_ST_BPH:`SEC_ST_BPL];
				end
			end else if (pcnt < `SEC_PAGE_BYTES) begin
				mem_we = pg_vld[pcnt[5:0]] && !prot;
			end
			if (pcnt == PROG_CYCLES - 1) begin
				next_busy = 1'b0;
			end
		end
	end

	// Programming registers; protection bits clear at reset
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			busy    <= 1'b0;
			pcnt    <= 32'h0;
			prog_st <= 1'b0;
			pin_en  <= 1'b0;
			bp      <= 2'h0;
		end else begin
			busy    <= next_busy;
			pcnt    <= next_pcnt;
			prog_st <= next_prog_st;
			pin_en  <= next_pin_en;
			bp      <= next_bp;
		end
	end

	// Array cells
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem[prog_addr] <= pg_data[pcnt[5:0]];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	a_desel_hiz: assert property (cs_hi |=> so_oe_n_o)
		else $error("Output driven while deselected");
	a_hold_freeze: assert property (paused && sck_rise && !cs_hi && !cs_fall |=>
		$stable(state) && $stable(sr) && $stable(bcnt))
		else $error("Shift moved while paused");
	a_busy_ff: assert property (rise_ok && state == ST_OPC && bcnt == 4'h7 && busy
		&& op == `SEC_OP_SRD |=> osr == 8'hff && !so_oe_n_o)
		else $error("Busy status read not all ones");
	a_latch_auto: assert property (start_arr || start_st |=> !wen && busy)
		else $error("Latch not cleared at programming");
	a_start_gate: assert property (start_arr || start_st |-> wen && wdone && cs_rise)
		else $error("Programming without latch or byte");
	a_protect_kept: assert property (mem_we |-> !prot && !prog_st)
		else $error("Protected byte written");
	a_busy_hold: assert property (start_arr || start_st |=> busy [*8])
		else $error("Busy dropped early");
	a_wp_refuse: assert property (start_st |-> !(pin_en && wp_lo))
		else $error("Status write under protect pin");
	a_read_wrap: assert property (fall_ok && !oe_n && state == ST_RDAT && bcnt == 4'h7
		&& addr == `SEC_TOP_ADDR |=> addr == 14'h0)
		else $error("Read address did not wrap");

	c_array_prog: cover property (start_arr);
	c_status_prog: cover property (start_st);
	c_busy_poll: cover property (rise_ok && state == ST_OPC && bcnt == 4'h7 && busy);
	c_paused: cover property (paused && sck_rise);

endmodule

// ===== design/sec_defines.svh
// Constants of the SPI EEPROM command slave: opcodes, status layout, timing.
// Assumes inclusion by bare name from the top module.
//
// Contract
// - Hold low with clock low pauses transfer
// - Hold high with clock low resumes exactly
// - Paused transfer ignores every serial clock edge
// - Select fall starts instruction; all fields MSB first
// - Read/write opcodes, 16-bit address, low 14 used
// - Latch set/clear opcodes carry nothing further
// - Status read shifts out, status write in
// - Latch clear after power-up; refuses programming
// - Status byte layout: enable, protect, latch, busy
// - Latch bit read-only, set/cleared by opcodes
// - Busy bit reads one while programming
// - Protect field selects read-only upper region
// - Protected bytes never altered by array write
// - Protect pin low with enable refuses status write
// - Status protection bits programmed like array bytes
// - Latch cleared automatically after each programming
// - Write while latch clear ignored until deselect
// - Programming starts only on deselect after D0
// - Busy accepts only status read, returning FF
// - Page write wraps within 64-byte page
// - Read streams with increment, wraps at top
// - After read address, input data ignored
// - Input sampled on serial clock rising edge
// - Deselected: input ignored, output high impedance
// - Unknown opcode ignored until select toggles
`ifndef SEC_DEFINES_SVH
`define SEC_DEFINES_SVH
`define SEC_OP_MASK     8'hf7
`define SEC_OP_READ     8'h03
`define SEC_OP_WRITE    8'h02
`define SEC_OP_LSET     8'h06
`define SEC_OP_LCLR     8'h04
`define SEC_OP_SRD      8'h05
`define SEC_OP_SWR      8'h01
`define SEC_ST_PINEN    7
`define SEC_ST_BPH      3
`define SEC_ST_BPL      2
`define SEC_PIN_IDLE    5'h19
`define SEC_BUSY_BYTE   8'hff
`define SEC_BP01_BASE   14'h3000
`define SEC_BP10_BASE   14'h2000
`define SEC_TOP_ADDR    14'h3fff
`define SEC_PAGE_BYTES  32'd64
`define SEC_CLK_NS      50
`define SEC_PROG_NS     5000000
`define SEC_PROG_CYCLES ((`SEC_PROG_NS) / (`SEC_CLK_NS))
`endif

// ===== design/sec_pkg.sv
// Types of the SPI EEPROM command slave.
// Assumes nothing beyond a SystemVerilog compiler.
package sec_pkg;
	// Serial command phases, one-hot
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_OPC  = 8'h02,
		ST_ADDR = 8'h04,
		ST_WDAT = 8'h08,
		ST_RDAT = 8'h10,
		ST_SRD  = 8'h20,
		ST_SWR  = 8'h40,
		ST_IGN  = 8'h80
	} sec_state_t;
endpackage

// ===== testbench/sec_spi_master.sv
// Serial bus master model that frames instructions for the EEPROM slave.
// Assumes the slave samples its pins with clk_i; every pin moves on a clk_i rise.
`timescale 1ns/100ps
module sec_spi_master (
	input  wire logic clk_i,
	input  wire logic so_i,
	input  wire logic so_oe_n_i,
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      si_o,
	output logic      hold_n_o
);
	logic [7:0] tx_q[$];    // Bytes to send
	logic [7:0] rx_q[$];    // Bytes seen, one per byte sent
	logic       drove;      // Output enabled in this frame
	logic       tgl = 1'b0; // Changing level of a floating line
	logic       so_w;       // Level on the data-out wire

	////////////////////////////////////////////////////////////////
	// A floating line must never repeat the last driven bit
	assign so_w = so_oe_n_i ? tgl : so_i;

	always @(posedge clk_i) begin
		tgl <= ~tgl;
	end

	// Idle pins: deselected, clock still and low
	initial begin
		cs_n_o   = 1'b1;
		sck_o    = 1'b0;
		si_o     = 1'b0;
		hold_n_o = 1'b1;
		drove    = 1'b0;
	end

	task automatic ticks(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	////////////////////////////////////////////////////////////////
	// One frame of tx_q; pauses before raising bit hold_at
	task automatic frame(input int hold_at);
		logic [7:0] r;
		int         k;
		rx_q   = {};
		drove  = 1'b0;
		k      = 0;
		cs_n_o <= 1'b0; // Fresh select per opcode
		ticks(8);
		foreach (tx_q[i]) begin
			for (int j = 7; j >= 0; j--) begin
				sck_o <= 1'b0;
				si_o  <= tx_q[i][j]; // MSB first
				ticks(4);
				if (k == hold_at) begin
					hold_n_o <= 1'b0; // Only with clock low
					ticks(6);
					sck_o <= 1'b1; // Edges to be ignored
					ticks(8);
					sck_o <= 1'b0;
					ticks(8);
					hold_n_o <= 1'b1; // Clock low again
					ticks(6);
				end
				sck_o <= 1'b1;
				ticks(4);
				r[j] = so_w; // Late in the high phase
				if (so_oe_n_i === 1'b0) begin
					drove = 1'b1;
				end
				k++;
			end
			rx_q.push_back(r);
		end
		sck_o <= 1'b0;
		ticks(4);
		cs_n_o <= 1'b1; // After D0, before a new rise
		si_o   <= ~si_o; // No stale bit on a released line
		ticks(8);
	endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the EEPROM command slave, through a master model.
// Assumes PROG_CYCLES sets the busy length in clk_i cycles.
`timescale 1ns/100ps
`include "sec_defines.svh"
module tb;
	localparam int PROG = 400; // Busy outlasts a status-read frame

	logic        clk_i;
	logic        rstn_i;
	logic        cs_n;
	logic        sck;
	logic        si;
	logic        wp_n;
	logic        hold_n;
	logic        so;
	logic        so_oe_n;
	int          err_total;
	int          total_checks;
	logic [7:0]  mem [int]; // Expected array contents
	logic [15:0] pa [6] = '{16'h0000, 16'h1fff, 16'h2000, 16'h2fff, 16'h3000, 16'h3fff};

	sec_spi_eeprom #(.PROG_CYCLES(PROG)) i_dut (
		.clk_i     (clk_i),
		.rstn_i    (rstn_i),
		.cs_n_i    (cs_n),
		.sck_i     (sck),
		.si_i      (si),
		.wp_n_i    (wp_n),
		.hold_n_i  (hold_n),
		.so_o      (so),
		.so_oe_n_o (so_oe_n)
	);

	sec_spi_master i_mst (
		.clk_i     (clk_i),
		.so_i      (so),
		.so_oe_n_i (so_oe_n),
		.cs_n_o    (cs_n),
		.sck_o     (sck),
		.si_o      (si),
		.hold_n_o  (hold_n)
	);

	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic prot(input logic [13:0] a, input logic [1:0] bp);
		return (bp == 2'h3) || (bp == 2'h2 && a >= 14'h2000) || (bp == 2'h1 && a >= 14'h3000);
	endfunction

	task automatic cmd(input logic [7:0] op);
		i_mst.tx_q = {op};
		i_mst.frame(-1);
	endtask

	// Status read of two bytes; the byte repeats
	task automatic st_chk(input logic [7:0] exp, input logic [7:0] mask);
		i_mst.tx_q = {`SEC_OP_SRD, 8'h00, 8'h00};
		i_mst.frame(-1);
		check("status", i_mst.rx_q[1] & mask, exp);
		check("status again", i_mst.rx_q[2] & mask, exp);
	endtask

	task automatic stat_wr(input logic [7:0] v);
		cmd(`SEC_OP_LSET);
		i_mst.tx_q = {`SEC_OP_SWR, v};
		i_mst.frame(-1);
		repeat (PROG) @(posedge clk_i);
	endtask

	// Array write of wq at a; s is the status expected afterwards
	task automatic wr(input logic [15:0] a, input logic [7:0] wq[$], input logic [7:0] s);
		logic [13:0] x;
		cmd(`SEC_OP_LSET);
		i_mst.tx_q = {`SEC_OP_WRITE, a[15:8], a[7:0], wq};
		i_mst.frame(-1);
		foreach (wq[i]) begin
			x = {a[13:6], a[5:0] + 6'(i)};
			if (!prot(x, s[3:2])) begin
				mem[x] = wq[i];
			end
		end
		// Only with the protect field clear
		if (s[3:2] == 2'h0) begin
			st_chk(8'hff, 8'hff);
			cmd(`SEC_OP_LSET); // Ignored while busy
		end
		repeat (PROG) @(posedge clk_i);
		st_chk(s, 8'h8f);
	endtask

	// Array read of n bytes with junk opcodes on the input
	task automatic rd(input logic [15:0] a, input int n, input int hold_at);
		logic [13:0] x;
		i_mst.tx_q = {`SEC_OP_READ, a[15:8], a[7:0]};
		repeat (n) i_mst.tx_q.push_back(`SEC_OP_LSET);
		i_mst.frame(hold_at);
		for (int i = 0; i < n; i++) begin
			x = a[13:0] + 14'(i);
			check("array byte", i_mst.rx_q[i + 3], mem[x]);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Watchdog, about twice the expected run
	initial begin
		repeat (90000) @(posedge clk_i);
		err_total++;
		print_verdict();
	end

	initial begin
		logic [7:0] pg[$];
		err_total    = 0;
		total_checks = 0;
		wp_n         = 1'b1;
		rstn_i       = 1'b0;
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		check("idle enable", so_oe_n, 1'b1);
		st_chk(8'h00, 8'h8f);
		cmd(`SEC_OP_LSET | 8'h08); // Don't-care bit set
		st_chk(8'h02, 8'h8f);
		cmd(`SEC_OP_LCLR | 8'h08);
		st_chk(8'h00, 8'h8f);
		i_mst.tx_q = {8'h07, `SEC_OP_SRD, 8'h00};
		i_mst.frame(-1);
		check("floating", i_mst.drove, 1'b0);
		// Each protect code against both sides of every boundary
		for (int bp = 0; bp < 4; bp++) begin
			stat_wr({4'h0, 2'(bp), 2'h0});
			foreach (pa[k]) wr(pa[k], {8'(16 * bp + k)}, {4'h0, 2'(bp), 2'h0});
			foreach (pa[k]) rd(pa[k], 1, -1);
		end
		rd(16'h3fff, 2, -1);
		stat_wr(8'h00);
		i_mst.tx_q = {`SEC_OP_WRITE, 8'h00, 8'h00, 8'h77};
		i_mst.frame(-1);
		st_chk(8'h00, 8'h8f);
		rd(16'h0000, 1, -1);
		for (int i = 0; i < 66; i++) pg.push_back(8'h10 + 8'(i));
		wr(16'hc13e, pg, 8'h00);
		rd(16'h4100, 64, 200);
		stat_wr(8'h80);
		st_chk(8'h80, 8'h8f);
		wp_n <= 1'b0;
		stat_wr(8'h8c);
		st_chk(8'h80, 8'h8d);
		wp_n <= 1'b1;
		stat_wr(8'h0c);
		st_chk(8'h0c, 8'h8f);
		print_verdict();
	end
endmodule
